// File: hdl/emr_pkg.sv
package emr_pkg;

    // ********************************************************************
    // widths and reset values
    // ********************************************************************
    localparam int          EMR_DATA_W    = 8;
    localparam int          EMR_ADDR_W    = 8;
    localparam int          EMR_MSB       = 7;
    localparam logic [7:0]  EMR_WORK_RST  = 8'h00;
    localparam logic [7:0]  EMR_ZERO_BYTE = 8'h00;
    localparam logic        EMR_CARRY_RST = 1'b0;
    localparam logic        EMR_ZERO_RST  = 1'b0;

    // ********************************************************************
    // operation codes
    // ********************************************************************
    typedef enum logic [2:0] {
        EMR_LONG_COPY_OP_TO_WORK                   = 3'h0,
        EMR_LONG_COPY_OP_TO_MEMORY                 = 3'h1,
        EMR_LONG_OR_TO_WORK                        = 3'h2,
        EMR_LONG_OR_TO_MEMORY                      = 3'h3,
        EMR_LONG_ROTATE_LEFT                       = 3'h4,
        EMR_LONG_ROTATE_LEFT_TO_WORK               = 3'h5,
        EMR_LONG_ROTATE_LEFT_THROUGH_CARRY         = 3'h6,
        EMR_LONG_ROTATE_LEFT_THROUGH_CARRY_TO_WORK = 3'h7
    } emr_op_t;

endpackage : emr_pkg

// File: hdl/emr_alu_if.sv
`timescale 1ns/1ns
interface emr_alu_if;
    import emr_pkg::*;

    emr_op_t          op;
    logic [7:0]       work;
    logic [7:0]       mem;
    logic             carry_in;
    logic [7:0]       result;
    logic             carry_out;
    logic             wr_work;
    logic             wr_mem;
    logic             upd_zero;
    logic             upd_carry;

    modport alu (
        input  op, work, mem, carry_in,
        output result, carry_out, wr_work, wr_mem, upd_zero, upd_carry
    );
    modport core (
        output op, work, mem, carry_in,
        input  result, carry_out, wr_work, wr_mem, upd_zero, upd_carry
    );
endinterface : emr_alu_if

// File: hdl/emr_alu.sv
`timescale 1ns/1ns
module emr_alu
    import emr_pkg::*;
(
    emr_alu_if.alu bus
);

    // ********************************************************************
    // operation decode and result
    // ********************************************************************
    always_comb begin
        bus.result    = bus.mem;
        bus.carry_out = bus.carry_in;
        bus.wr_work   = 1'b0;
        bus.wr_mem    = 1'b0;
        bus.upd_zero  = 1'b0;
        bus.upd_carry = 1'b0;
        case (bus.op)
            EMR_LONG_COPY_OP_TO_WORK: begin
                bus.result  = bus.mem;
                bus.wr_work = 1'b1;
            end
            EMR_LONG_COPY_OP_TO_MEMORY: begin
                bus.result = bus.work;
                bus.wr_mem = 1'b1;
            end
            EMR_LONG_OR_TO_WORK: begin
                bus.result   = bus.work | bus.mem;
                bus.wr_work  = 1'b1;
                bus.upd_zero = 1'b1;
            end
            EMR_LONG_OR_TO_MEMORY: begin
                bus.result   = bus.work | bus.mem;
                bus.wr_mem   = 1'b1;
                bus.upd_zero = 1'b1;
            end
            EMR_LONG_ROTATE_LEFT: begin
                bus.result = {bus.mem[EMR_MSB-1:0], bus.mem[EMR_MSB]};
                bus.wr_mem = 1'b1;
            end
            EMR_LONG_ROTATE_LEFT_TO_WORK: begin
                bus.result  = {bus.mem[EMR_MSB-1:0], bus.mem[EMR_MSB]};
                bus.wr_work = 1'b1;
            end
            EMR_LONG_ROTATE_LEFT_THROUGH_CARRY: begin
                bus.result    = {bus.mem[EMR_MSB-1:0], bus.carry_in};
                bus.carry_out = bus.mem[EMR_MSB];
                bus.wr_mem    = 1'b1;
                bus.upd_carry = 1'b1;
            end
            EMR_LONG_ROTATE_LEFT_THROUGH_CARRY_TO_WORK: begin
                bus.result    = {bus.mem[EMR_MSB-1:0], bus.carry_in};
                bus.carry_out = bus.mem[EMR_MSB];
                bus.wr_work   = 1'b1;
                bus.upd_carry = 1'b1;
            end
            default: begin
                bus.result = bus.mem;
            end
        endcase
    end

endmodule : emr_alu

// File: hdl/emr_exec_unit.sv
`timescale 1ns/1ns
module emr_exec_unit
    import emr_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  arst_n_i,
    // operation request
    input  wire logic                  op_valid_i,
    input  wire emr_op_t               op_code_i,
    input  wire logic [EMR_ADDR_W-1:0] op_addr_i,
    input  wire logic [EMR_DATA_W-1:0] mem_rdata_i,
    // memory write-back
    output logic                       mem_we_o,
    output logic      [EMR_ADDR_W-1:0] mem_waddr_o,
    output logic      [EMR_DATA_W-1:0] mem_wdata_o,
    // architectural state
    output logic      [EMR_DATA_W-1:0] working_register_o,
    output logic                       carry_o,
    output logic                       zero_o,
    output logic                       done_o
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [EMR_DATA_W-1:0] work;
        logic                  carry;
        logic                  zero;
        logic                  mem_we;
        logic [EMR_ADDR_W-1:0] mem_waddr;
        logic [EMR_DATA_W-1:0] mem_wdata;
        logic                  done;
    } emr_state_t;

    emr_state_t state_reg;
    emr_state_t state_next;

    emr_alu_if alu_bus ();

    assign alu_bus.op       = op_code_i;
    assign alu_bus.work     = state_reg.work;
    assign alu_bus.mem      = mem_rdata_i;
    assign alu_bus.carry_in = state_reg.carry;

    emr_alu u_alu (
        .bus (alu_bus.alu)
    );

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        state_next        = state_reg;
        state_next.mem_we = 1'b0;
        state_next.done   = 1'b0;
        if (op_valid_i) begin
            state_next.done = 1'b1;
            if (alu_bus.wr_work) begin
                state_next.work = alu_bus.result;
            end
            if (alu_bus.wr_mem) begin
                state_next.mem_we    = 1'b1;
                state_next.mem_waddr = op_addr_i;
                state_next.mem_wdata = alu_bus.result;
            end
            if (alu_bus.upd_zero) begin
                state_next.zero = (alu_bus.result == EMR_ZERO_BYTE);
            end
            if (alu_bus.upd_carry) begin
                state_next.carry = alu_bus.carry_out;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg.work      <= EMR_WORK_RST;
            state_reg.carry     <= EMR_CARRY_RST;
            state_reg.zero      <= EMR_ZERO_RST;
            state_reg.mem_we    <= 1'b0;
            state_reg.mem_waddr <= '0;
            state_reg.mem_wdata <= EMR_ZERO_BYTE;
            state_reg.done      <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign mem_we_o           = state_reg.mem_we;
    assign mem_waddr_o        = state_reg.mem_waddr;
    assign mem_wdata_o        = state_reg.mem_wdata;
    assign working_register_o = state_reg.work;
    assign carry_o            = state_reg.carry;
    assign zero_o             = state_reg.zero;
    assign done_o             = state_reg.done;

endmodule : emr_exec_unit

// File: test/emr_monitor.sv
`timescale 1ns/1ns
module emr_monitor
    import emr_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       arst_n_i,
    // request
    input wire logic       op_valid_i,
    input wire emr_op_t    op_code_i,
    input wire logic [7:0] op_addr_i,
    input wire logic [7:0] mem_rdata_i,
    // results
    input wire logic       mem_we_o,
    input wire logic [7:0] mem_waddr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] working_register_o,
    input wire logic       carry_o,
    input wire logic       zero_o,
    input wire logic       done_o
);
    logic [7:0] rdata_reg;
    logic [7:0] work_reg;
    logic       carry_reg;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // operands of the request taken at the previous edge
    always_ff @(posedge clk_sys_i) begin
        rdata_reg <= mem_rdata_i;
        work_reg  <= working_register_o;
        carry_reg <= carry_o;
    end
    a_copy_work: assert property (
        op_valid_i && op_code_i == EMR_LONG_COPY_OP_TO_WORK |=>
        working_register_o == rdata_reg && $stable({carry_o, zero_o}) && !mem_we_o)
        else $error("copy to work");
    a_copy_mem: assert property (
        op_valid_i && op_code_i == EMR_LONG_COPY_OP_TO_MEMORY |=>
        mem_we_o && mem_wdata_o == work_reg && mem_waddr_o == $past(op_addr_i)
        && $stable({working_register_o, carry_o, zero_o}))
        else $error("copy to mem");
    a_or_work: assert property (
        op_valid_i && op_code_i == EMR_LONG_OR_TO_WORK |=>
        working_register_o == (work_reg | rdata_reg) && !mem_we_o
        && zero_o == ((work_reg | rdata_reg) == 8'h00) && $stable(carry_o))
        else $error("or to work");
    a_or_mem: assert property (
        op_valid_i && op_code_i == EMR_LONG_OR_TO_MEMORY |=>
        mem_we_o && mem_wdata_o == (work_reg | rdata_reg) && mem_waddr_o == $past(op_addr_i)
        && zero_o == ((work_reg | rdata_reg) == 8'h00) && $stable({working_register_o, carry_o}))
        else $error("or to mem");
    a_rot_mem: assert property (
        op_valid_i && op_code_i == EMR_LONG_ROTATE_LEFT |=>
        mem_we_o && mem_wdata_o == {rdata_reg[6:0], rdata_reg[7]}
        && mem_waddr_o == $past(op_addr_i) && $stable({working_register_o, carry_o, zero_o}))
        else $error("rotate to mem");
    a_rot_work: assert property (
        op_valid_i && op_code_i == EMR_LONG_ROTATE_LEFT_TO_WORK |=>
        !mem_we_o && working_register_o == {rdata_reg[6:0], rdata_reg[7]}
        && $stable({carry_o, zero_o}))
        else $error("rotate to work");
    a_rlc_mem: assert property (
        op_valid_i && op_code_i == EMR_LONG_ROTATE_LEFT_THROUGH_CARRY |=>
        mem_we_o && mem_wdata_o == {rdata_reg[6:0], carry_reg} && carry_o == rdata_reg[7]
        && mem_waddr_o == $past(op_addr_i) && $stable({working_register_o, zero_o}))
        else $error("carry rotate to mem");
    a_rlc_work: assert property (
        op_valid_i && op_code_i == EMR_LONG_ROTATE_LEFT_THROUGH_CARRY_TO_WORK |=>
        !mem_we_o && working_register_o == {rdata_reg[6:0], carry_reg}
        && carry_o == rdata_reg[7] && $stable(zero_o))
        else $error("carry rotate to work");
    a_done_pulse: assert property (op_valid_i |=> done_o) else $error("request not answered");
    a_idle_hold: assert property (!op_valid_i |=> !done_o && !mem_we_o
        && $stable({working_register_o, carry_o, zero_o})) else $error("idle changed state");
endmodule : emr_monitor

// File: test/extended_move_or_rotate_ops_bench.sv
`timescale 1ns/1ns
module extended_move_or_rotate_ops_bench;
    import emr_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        op_valid_i = 1'b0;
    emr_op_t     op_code_i = EMR_LONG_COPY_OP_TO_WORK;
    logic [7:0]  op_addr_i = 8'h00;
    logic [7:0]  mem_rdata_i = 8'h00;
    logic        mem_we_o, carry_o, zero_o, done_o;
    logic [7:0]  mem_waddr_o, mem_wdata_o, working_register_o;
    int          n_fail = 0;
    int          total_checks = 0;
    int          op;
    logic [7:0]  mem [4];
    logic [27:0] exp_prev, exp_new;
    logic [7:0]  w, wa, wd, d, r;
    logic [1:0]  a;
    logic        c, z, we, v;
    wire  [27:0] seen = {done_o, mem_we_o, mem_waddr_o, mem_wdata_o,
                         working_register_o, carry_o, zero_o};
    always #50 clk_sys_i = ~clk_sys_i;
    emr_exec_unit uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .op_addr_i(op_addr_i), .mem_rdata_i(mem_rdata_i),
        .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
        .working_register_o(working_register_o), .carry_o(carry_o), .zero_o(zero_o),
        .done_o(done_o));
    task check(input logic [27:0] got, input logic [27:0] expd);
        total_checks++;
        if (got !== expd) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, got, expd);
        end
    endtask : check
    task results();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (1200) @(posedge clk_sys_i);
        n_fail++;
        results();
    end
    initial begin
        r = 8'($urandom(32'h705e7919));
        {w, c, z, wa, wd, exp_prev} = '0;
        for (int i = 0; i < 4; i++) mem[i] = 8'($urandom);
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        check(seen, 28'h0000000);
        repeat (600) begin
            @(posedge clk_sys_i);
            v = ($urandom % 5) != 0;
            op = $urandom % 8;
            a = 2'($urandom);
            // memory byte sometimes cleared by another agent to reach zero results
            d = ($urandom % 6 == 0) ? 8'h00 : mem[a];
            mem[a] = d;
            we = 1'b0;
            op_valid_i <= v;
            op_code_i <= emr_op_t'(op);
            op_addr_i <= {6'h00, a};
            mem_rdata_i <= d;
            if (v) begin
                case (op)
                    0: w = d;
                    1: begin r = w; we = 1'b1; end
                    2: begin w = w | d; z = (w == 8'h00); end
                    3: begin r = w | d; z = (r == 8'h00); we = 1'b1; end
                    4: begin r = {d[6:0], d[7]}; we = 1'b1; end
                    5: w = {d[6:0], d[7]};
                    6: begin r = {d[6:0], c}; c = d[7]; we = 1'b1; end
                    default: begin w = {d[6:0], c}; c = d[7]; end
                endcase
                if (we) begin wa = {6'h00, a}; wd = r; mem[a] = r; end
            end
            exp_new = {v, we, wa, wd, w, c, z};
            @(negedge clk_sys_i);
            check(28'(seen[27:10]), 28'(exp_prev[27:10]));
            check(28'(seen[9:2]), 28'(exp_prev[9:2]));
            check(28'(seen[1:0]), 28'(exp_prev[1:0]));
            exp_prev = exp_new;
        end
        results();
    end
endmodule : extended_move_or_rotate_ops_bench
bind emr_exec_unit emr_monitor mon (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_addr_i(op_addr_i),
    .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
    .mem_wdata_o(mem_wdata_o), .working_register_o(working_register_o),
    .carry_o(carry_o), .zero_o(zero_o), .done_o(done_o));
